// >>> logic/csu_pkg.sv
// Package for the configurable serial transceiver: constants, types, register map
package csu_pkg;
    // Clock and baud
    localparam int unsigned CLK_HZ = 100000000;
    localparam int unsigned BAUD_4800 = 4800;
    localparam int unsigned BAUD_9600 = 9600;
    localparam int unsigned BAUD_19200 = 19200;
    localparam int unsigned BAUD_38400 = 38400;
    localparam int unsigned BAUD_57600 = 57600;
    localparam int unsigned BAUD_115200 = 115200;
    localparam int DIV_W = 16;
    // Register byte addresses
    localparam logic [11:0] ADDR_CTRL = 12'h000;
    localparam logic [11:0] ADDR_STAT = 12'h004;
    localparam logic [11:0] ADDR_TXD = 12'h008;
    localparam logic [11:0] ADDR_RXD = 12'h00C;
    // Control field positions
    localparam int CTRL_BAUD_LSB = 0;
    localparam int CTRL_DBITS_LSB = 4;
    localparam int CTRL_PAR_LSB = 6;
    localparam int CTRL_STOP_POS = 8;
    // Reset value: 9600 baud, 8 data bits, no parity, one stop bit
    localparam logic [2:0] CTRL_BAUD_RST = 3'h1;
    localparam logic [1:0] CTRL_DBITS_RST = 2'h3;
    localparam logic [1:0] CTRL_PAR_RST = 2'h0;
    localparam logic CTRL_STOP_RST = 1'b0;
    // Status bit positions
    localparam int STAT_TXRDY = 0;
    localparam int STAT_RXVALID = 1;
    localparam int STAT_PARERR = 2;
    localparam int STAT_FRMERR = 3;
    localparam int STAT_OVERRUN = 4;
    localparam int STAT_TXBUSY = 5;

    typedef enum logic [1:0] {CSU_PAR_NONE, CSU_PAR_ODD, CSU_PAR_EVEN, CSU_PAR_RSVD} csu_parity_type;

    typedef struct packed {
        logic [2:0] baudSel;
        logic [1:0] dataBits;
        csu_parity_type parity;
        logic twoStop;
    } csu_cfg_type;

    typedef struct packed {
        logic [7:0] data;
        logic parErr;
        logic frmErr;
    } csu_rxword_type;

    function automatic logic [DIV_W-1:0] csu_divisor(input logic [2:0] sel);
        int unsigned b;
        case (sel)
            3'h0: b = BAUD_4800;
            3'h1: b = BAUD_9600;
            3'h2: b = BAUD_19200;
            3'h3: b = BAUD_38400;
            3'h4: b = BAUD_57600;
            default: b = BAUD_115200;
        endcase
        csu_divisor = DIV_W'((CLK_HZ + b / 2) / b - 1);
    endfunction
endpackage

// >>> logic/csu_uart.sv
// Configurable serial transceiver with APB registers and two-entry receive buffer
// What this block does
// - Transmit and receive both run at one selectable rate of 4800, 9600, 19200, 38400, 57600 or 115200 baud.
// - Characters carry five, six, seven or eight data bits, the same width in both directions.
// - Parity is none, odd or even, generated on transmit and checked on receive.
// - Each transmitted character ends with one or two stop bits as selected.
//
// Added by the designer: register access over APB and the placing of the registers.
module csu_uart
    import csu_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic clkEn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic rxPin,
    output logic txPin
);
    // ----------------------------------------
    // Registers and APB decode
    // ----------------------------------------
    csu_cfg_type cfg_q;
    logic [DIV_W-1:0] divisor;
    logic apbWr, apbRd, hitAny;
    logic overrun_q, overrunSet, overrunClr;
    logic rxdSeen_q;
    logic txLoad, txBusy_q;
    logic [7:0] txHold_q;
    logic bufOutValid, bufOutReady, bufInValid, bufInReady;
    csu_rxword_type bufIn, bufOut;

    assign divisor = csu_divisor(cfg_q.baudSel);
    assign apbWr = psel && penable && pwrite;
    assign apbRd = psel && penable && !pwrite;
    assign hitAny = (paddr == ADDR_CTRL) || (paddr == ADDR_STAT) || (paddr == ADDR_TXD) || (paddr == ADDR_RXD);
    assign pready = 1'b1;
    assign pslverr = psel && penable && !hitAny;

    // Line configuration; a change mid-character corrupts that character
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cfg_q <= '{CTRL_BAUD_RST, CTRL_DBITS_RST, csu_parity_type'(CTRL_PAR_RST), CTRL_STOP_RST};
        end
        else if (clkEn && apbWr && paddr == ADDR_CTRL)
        begin
            cfg_q.baudSel <= pwdata[CTRL_BAUD_LSB +: 3];
            cfg_q.dataBits <= pwdata[CTRL_DBITS_LSB +: 2];
            cfg_q.parity <= csu_parity_type'(pwdata[CTRL_PAR_LSB +: 2]);
            cfg_q.twoStop <= pwdata[CTRL_STOP_POS];
        end
    end

    // Read data is registered; reading RXD pops the buffer, but only a char that was shown
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            prdata <= 32'h00000000;
            rxdSeen_q <= 1'b0;
        end
        else if (clkEn && psel && !penable && !pwrite)
        begin
            prdata <= 32'h00000000;
            rxdSeen_q <= paddr == ADDR_RXD && bufOutValid;
            case (paddr)
                ADDR_CTRL: prdata[8:0] <= {cfg_q.twoStop, cfg_q.parity, cfg_q.dataBits, 1'b0, cfg_q.baudSel};
                ADDR_STAT:
                begin
                    prdata[STAT_TXRDY] <= !txBusy_q;
                    prdata[STAT_RXVALID] <= bufOutValid;
                    prdata[STAT_PARERR] <= bufOutValid && bufOut.parErr;
                    prdata[STAT_FRMERR] <= bufOutValid && bufOut.frmErr;
                    prdata[STAT_OVERRUN] <= overrun_q;
                    prdata[STAT_TXBUSY] <= txBusy_q;
                end
                ADDR_RXD: prdata[7:0] <= bufOutValid ? bufOut.data : 8'h00;
                default: prdata <= 32'h00000000;
            endcase
        end
    end

    // Pop and clear only what the setup cycle showed; later arrivals survive
    assign bufOutReady = clkEn && apbRd && paddr == ADDR_RXD && rxdSeen_q;
    assign overrunClr = clkEn && apbRd && paddr == ADDR_STAT && prdata[STAT_OVERRUN];

    // Overrun is sticky; a new overrun wins over the clearing read
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            overrun_q <= 1'b0;
        else if (clkEn)
            overrun_q <= overrunSet ? 1'b1 : (overrunClr ? 1'b0 : overrun_q);
    end

    // ----------------------------------------
    // Transmitter
    // ----------------------------------------
    typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_STOP} csu_txstate_type;
    csu_txstate_type txState_q;
    logic [DIV_W-1:0] txCnt_q;
    logic [2:0] txBit_q;
    logic txPar_q, txStop2_q;
    logic txTick;

    assign txLoad = clkEn && apbWr && paddr == ADDR_TXD && !txBusy_q;
    // A count left above a lowered divisor ends the bit at once instead of running long
    assign txTick = txCnt_q == '0 || txCnt_q > divisor;

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            txState_q <= TX_IDLE;
            txCnt_q <= '0;
            txBit_q <= 3'h0;
            txPar_q <= 1'b0;
            txStop2_q <= 1'b0;
            txHold_q <= 8'h00;
            txBusy_q <= 1'b0;
            txPin <= 1'b1;
        end
        else if (clkEn)
        begin
            txCnt_q <= txTick ? divisor : txCnt_q - 1'b1;
            case (txState_q)
                TX_IDLE:
                begin
                    txPin <= 1'b1;
                    if (txLoad)
                    begin
                        txHold_q <= pwdata[7:0];
                        txPar_q <= cfg_q.parity == CSU_PAR_ODD;
                        txBusy_q <= 1'b1;
                        txCnt_q <= divisor;
                        txPin <= 1'b0;
                        txState_q <= TX_START;
                    end
                end
                TX_START:
                    if (txTick)
                    begin
                        txPin <= txHold_q[0];
                        txPar_q <= txPar_q ^ txHold_q[0];
                        txHold_q <= txHold_q >> 1;
                        txBit_q <= 3'h0;
                        txState_q <= TX_DATA;
                    end
                TX_DATA:
                    if (txTick)
                    begin
                        if (txBit_q == {1'b1, cfg_q.dataBits})
                        begin
                            txStop2_q <= cfg_q.twoStop;
                            if (cfg_q.parity == CSU_PAR_ODD || cfg_q.parity == CSU_PAR_EVEN)
                            begin
                                txPin <= txPar_q;
                                txState_q <= TX_PAR;
                            end
                            else
                            begin
                                txPin <= 1'b1;
                                txState_q <= TX_STOP;
                            end
                        end
                        else
                        begin
                            txPin <= txHold_q[0];
                            txPar_q <= txPar_q ^ txHold_q[0];
                            txHold_q <= txHold_q >> 1;
                            txBit_q <= txBit_q + 3'h1;
                        end
                    end
                TX_PAR:
                    if (txTick)
                    begin
                        txPin <= 1'b1;
                        txState_q <= TX_STOP;
                    end
                TX_STOP:
                    if (txTick)
                    begin
                        if (txStop2_q)
                            txStop2_q <= 1'b0;
                        else
                        begin
                            txBusy_q <= 1'b0;
                            txState_q <= TX_IDLE;
                        end
                    end
                default: txState_q <= TX_IDLE;
            endcase
        end
    end

    // ----------------------------------------
    // Receiver
    // ----------------------------------------
    typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP} csu_rxstate_type;
    csu_rxstate_type rxState_q;
    logic rxMeta_q, rxSync_q;
    logic [DIV_W-1:0] rxCnt_q;
    logic [2:0] rxBit_q;
    logic [7:0] rxShift_q;
    logic rxPar_q, rxParErr_q, rxTick;

    // Two-flop synchroniser; only the second stage feeds logic
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rxMeta_q <= 1'b1;
            rxSync_q <= 1'b1;
        end
        else if (clkEn)
        begin
            rxMeta_q <= rxPin;
            rxSync_q <= rxMeta_q;
        end
    end

    assign rxTick = rxCnt_q == '0;
    assign bufIn.data = rxShift_q >> (2'h3 - cfg_q.dataBits); // Right-justify short characters
    assign bufIn.parErr = rxParErr_q;
    assign bufIn.frmErr = !rxSync_q;
    assign bufInValid = clkEn && rxState_q == RX_STOP && rxTick;
    assign overrunSet = bufInValid && !bufInReady;

    // Samples at mid-bit: half a period after the start edge, then whole periods
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rxState_q <= RX_IDLE;
            rxCnt_q <= '0;
            rxBit_q <= 3'h0;
            rxShift_q <= 8'h00;
            rxPar_q <= 1'b0;
            rxParErr_q <= 1'b0;
        end
        else if (clkEn)
        begin
            rxCnt_q <= rxTick ? divisor : rxCnt_q - 1'b1;
            case (rxState_q)
                RX_IDLE:
                    if (!rxSync_q)
                    begin
                        rxCnt_q <= divisor >> 1;
                        rxState_q <= RX_START;
                    end
                RX_START:
                    if (rxTick)
                    begin
                        rxState_q <= rxSync_q ? RX_IDLE : RX_DATA; // False start rejected
                        rxBit_q <= 3'h0;
                        rxParErr_q <= 1'b0;
                        rxPar_q <= cfg_q.parity == CSU_PAR_ODD;
                    end
                RX_DATA:
                    if (rxTick)
                    begin
                        rxShift_q <= {rxSync_q, rxShift_q[7:1]};
                        rxPar_q <= rxPar_q ^ rxSync_q;
                        rxBit_q <= rxBit_q + 3'h1;
                        if (rxBit_q == {1'b1, cfg_q.dataBits})
                            rxState_q <= cfg_q.parity inside {CSU_PAR_ODD, CSU_PAR_EVEN} ? RX_PAR : RX_STOP;
                    end
                RX_PAR:
                    if (rxTick)
                    begin
                        rxParErr_q <= rxSync_q != rxPar_q;
                        rxState_q <= RX_STOP;
                    end
                RX_STOP:
                    if (rxTick)
                        rxState_q <= RX_IDLE; // One stop bit checked; a second is idle line
                default: rxState_q <= RX_IDLE;
            endcase
        end
    end

    // ----------------------------------------
    // Two-entry receive buffer
    // ----------------------------------------
    csu_rxword_type mem_q [2];
    logic [1:0] cnt_q;
    logic rdPtr_q, wrPtr_q, push, pop;

    assign bufInReady = cnt_q != 2'h2;
    assign bufOutValid = cnt_q != 2'h0;
    assign bufOut = mem_q[rdPtr_q];
    assign push = bufInValid && bufInReady;
    assign pop = bufOutReady && bufOutValid;

    // Full buffer drops the new character and flags overrun
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cnt_q <= 2'h0;
            rdPtr_q <= 1'b0;
            wrPtr_q <= 1'b0;
            mem_q[0] <= '0;
            mem_q[1] <= '0;
        end
        else if (clkEn)
        begin
            if (push)
            begin
                mem_q[wrPtr_q] <= bufIn;
                wrPtr_q <= !wrPtr_q;
            end
            if (pop)
                rdPtr_q <= !rdPtr_q;
            cnt_q <= cnt_q + 2'(push) - 2'(pop);
        end
    end

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    chk_tx_idle_high: assert property (@(posedge clk) disable iff (!rst_n)
        txState_q == TX_IDLE |-> txPin) else $error("tx line not high while idle");
    chk_tx_start_low: assert property (@(posedge clk) disable iff (!rst_n)
        txState_q == TX_START |-> !txPin) else $error("start bit not low");
    chk_tx_stop_high: assert property (@(posedge clk) disable iff (!rst_n)
        txState_q == TX_STOP |-> txPin) else $error("stop bit not high");
    chk_baud_period: assert property (@(posedge clk) disable iff (!rst_n)
        txCnt_q <= divisor || $changed(cfg_q)) else $error("bit counter beyond divisor");
    chk_par_skip: assert property (@(posedge clk) disable iff (!rst_n)
        txState_q == TX_DATA && txTick && txBit_q == {1'b1, cfg_q.dataBits} && cfg_q.parity == CSU_PAR_NONE
        |=> txState_q == TX_STOP) else $error("parity sent with none");
    chk_data_width: assert property (@(posedge clk) disable iff (!rst_n)
        rxState_q == RX_DATA |-> rxBit_q <= {1'b1, cfg_q.dataBits}) else $error("rx bit index past width");
    chk_buf_count: assert property (@(posedge clk) disable iff (!rst_n)
        cnt_q <= 2'h2) else $error("buffer count past depth");
    chk_tx_busy_load: assert property (@(posedge clk) disable iff (!rst_n)
        txLoad |=> txBusy_q && !txPin) else $error("load did not start frame");
endmodule

// >>> testbench/csu_host_model.sv
// Host serial port model: sends and captures framed characters
module csu_host_model
    import csu_pkg::*;
(
    input wire logic clk,
    output logic lineToDev,
    input wire logic lineFromDev
);
    timeunit 1ns;
    timeprecision 1ps;

    // Mark level rests between characters
    initial lineToDev = 1'b1;

    // One bit for a full period at the agreed rate
    task automatic hold_bit(input int per, input logic b);
        lineToDev <= b;
        repeat (per) @(posedge clk);
    endtask

    // Broken stop bit (bad[0]) or parity (bad[1]) only when a scenario asks for it
    task automatic send(input int per, input int n, input csu_parity_type p, input logic two,
        input logic [7:0] d, input logic [1:0] bad);
        @(posedge clk);
        hold_bit(per, 1'b0);
        for (int i = 0; i < n; i++) hold_bit(per, d[i]);
        if (p != CSU_PAR_NONE) hold_bit(per, (p == CSU_PAR_ODD) ^ (^d) ^ bad[1]);
        hold_bit(per, ~bad[0]);
        if (two) hold_bit(per, 1'b1);
        lineToDev <= 1'b1;
    endtask

    // Mid-bit sampling; waits out the last stop so the sender is idle on return
    task automatic recv(input int per, input int n, input csu_parity_type p, input logic two,
        output logic [7:0] d, output logic pb, output logic ok);
        d = 8'h00;
        pb = 1'b0;
        while (lineFromDev !== 1'b0) @(posedge clk);
        repeat (per / 2) @(posedge clk);
        ok = (lineFromDev === 1'b0);
        for (int i = 0; i < n; i++)
        begin
            repeat (per) @(posedge clk);
            d[i] = lineFromDev;
        end
        if (p != CSU_PAR_NONE)
        begin
            repeat (per) @(posedge clk);
            pb = lineFromDev;
        end
        repeat (per) @(posedge clk);
        ok = ok & (lineFromDev === 1'b1);
        if (two)
        begin
            repeat (per) @(posedge clk);
            ok = ok & (lineFromDev === 1'b1);
        end
        repeat (per / 2 + 2) @(posedge clk);
    endtask
endmodule

// >>> testbench/test_configurable_serial_uart.sv
// Self-checking bench for the configurable serial transceiver
module test_configurable_serial_uart
    import csu_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic clkEn = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic rxLine;
    logic txLine;
    int error_cnt = 0;
    int n_checks = 0;

    always #5 clk = ~clk;

    csu_uart u_dut(.clk(clk), .rst_n(rst_n), .clkEn(clkEn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .rxPin(rxLine),
        .txPin(txLine));
    csu_host_model u_host(.clk(clk), .lineToDev(rxLine), .lineFromDev(txLine));

    // --------------------------------
    // Bus and compare helpers
    // --------------------------------
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Request held until pready is seen high at an edge
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] r,
        output logic e);
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) @(posedge clk);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic e;
        apb(1'b1, a, d, r, e);
    endtask

    task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
        logic [31:0] r;
        logic e;
        apb(1'b0, a, 32'h0, r, e);
        check(r, exp);
    endtask

    // Bit period in clocks, rounded
    function automatic int per(input int s);
        int unsigned b[6] = '{BAUD_4800, BAUD_9600, BAUD_19200, BAUD_38400, BAUD_57600, BAUD_115200};
        return int'((CLK_HZ + b[s] / 2) / b[s]);
    endfunction

    task automatic do_reset();
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
    endtask

    // --------------------------------
    // Scenarios
    // --------------------------------
    task automatic t_reset();
        logic [31:0] r;
        logic e;
        rd_chk(ADDR_CTRL, 32'({CTRL_STOP_RST, CTRL_PAR_RST, CTRL_DBITS_RST, 1'b0, CTRL_BAUD_RST}));
        rd_chk(ADDR_STAT, 32'h1 << STAT_TXRDY);
        check(32'(txLine), 32'h1);
        apb(1'b0, 12'h010, 32'h0, r, e);
        check({r[30:0], e}, 32'h1);
        // A write while the enable is low must not land
        clkEn <= 1'b0;
        wr(ADDR_CTRL, 32'h0);
        clkEn <= 1'b1;
        rd_chk(ADDR_CTRL, 32'({CTRL_STOP_RST, CTRL_PAR_RST, CTRL_DBITS_RST, 1'b0, CTRL_BAUD_RST}));
        $display("test reset done");
    endtask

    // All-ones 8-bit char, so the low run is the start bit alone; reset cuts slow frames short
    task automatic t_rates();
        int n;
        for (int s = 0; s < 6; s++)
        begin
            do_reset();
            wr(ADDR_CTRL, 32'h30 | 32'(s));
            wr(ADDR_TXD, 32'hFF);
            n = 0;
            while (txLine !== 1'b0) @(posedge clk);
            while (txLine === 1'b0)
            begin
                n++;
                @(posedge clk);
            end
            check(32'(n), 32'(per(s)));
        end
        $display("test rates done");
    endtask

    // Full duplex per format; three chars arrive unread, so the third overruns; the last has bad parity
    task automatic t_formats();
        logic [1:0] db[4] = '{2'h3, 2'h0, 2'h2, 2'h1};
        csu_parity_type pt[4] = '{CSU_PAR_EVEN, CSU_PAR_ODD, CSU_PAR_NONE, CSU_PAR_EVEN};
        logic ts[4] = '{1'b1, 1'b0, 1'b1, 1'b0};
        logic [7:0] txv[4] = '{8'hA5, 8'h13, 8'h5A, 8'h2E};
        logic [7:0] rxv[4] = '{8'h3C, 8'h0B, 8'h71, 8'h25};
        logic [31:0] cfg;
        logic [31:0] st;
        logic [7:0] d;
        logic pb;
        logic ok;
        logic e;
        int p;
        int n;
        p = per(5);
        // Cut short the frame that the rate test left running
        do_reset();
        for (int i = 0; i < 4; i++)
        begin
            n = db[i] + 5;
            cfg = {23'h0, ts[i], pt[i], db[i], 1'b0, 3'h5};
            wr(ADDR_CTRL, cfg);
            rd_chk(ADDR_CTRL, cfg);
            fork
                u_host.recv(p, n, pt[i], ts[i], d, pb, ok);
                u_host.send(p, n, pt[i], ts[i], rxv[i], {i == 3, i == 1});
                wr(ADDR_TXD, 32'(txv[i]));
                begin
                    // Probe mid second stop slot: busy only with two stops
                    repeat (((n + int'(pt[i] != CSU_PAR_NONE)) * 2 + 5) * p / 2) @(posedge clk);
                    apb(1'b0, ADDR_STAT, 32'h0, st, e);
                    check({30'h0, st[5:4]}, {30'h0, ts[i], i == 2});
                end
            join
            check(32'(d), 32'(txv[i]));
            check({pb, ok}, {pt[i] == CSU_PAR_ODD ? ~^txv[i] : pt[i] == CSU_PAR_EVEN && ^txv[i], 1'b1});
            if (i == 2)
            begin
                rd_chk(ADDR_STAT, 32'h03);
                rd_chk(ADDR_RXD, 32'h3C);
                rd_chk(ADDR_STAT, 32'h0B);
                rd_chk(ADDR_RXD, 32'h0B);
                rd_chk(ADDR_STAT, 32'h01);
                rd_chk(ADDR_RXD, 32'h00);
            end
        end
        rd_chk(ADDR_STAT, 32'h07);
        rd_chk(ADDR_RXD, 32'h25);
        $display("test formats done");
    endtask

    task automatic conclude();
        $display("checks %0d mismatches %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    // Run is about 76k clocks; the limit stays under 100k
    initial
    begin
        repeat (95000) @(posedge clk);
        error_cnt++;
        conclude();
    end

    initial
    begin
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        t_reset();
        t_rates();
        t_formats();
        conclude();
    end
endmodule
